// ---- hdl/hpac_top.sv ----
// Headphone amplifier control: serial register slave, shutdown, soft-start, PFM, class G
// How it works
// RULE_01 - Output control bit 0 set floats the right output, clear drives it.
// RULE_02 - Output control bit 1 set floats the left output, clear drives it.
// RULE_03 - Output control bit 3 at 0x03 drives the low-distortion enable.
// RULE_04 - Mode control bit 0 is global power down; 1 off, 0 running.
// RULE_05 - Global power down resets to 1 so the device starts off.
// RULE_06 - Mode control bit 7 enables left amplifier, bit 6 enables right.
// RULE_07 - Left and right amplifier enables act independently.
// RULE_08 - Setting global power down runs a shutdown sequence finished within 3 ms.
// RULE_09 - Host waits 3 ms after power down before any further command.
// RULE_10 - Volume register bit 7 mutes left, bit 6 mutes right, independently.
// RULE_11 - Clearing a mute bit unmutes only that channel.
// RULE_12 - Both mute bits reset to 1.
// RULE_13 - Soft-start begins only on power down falling with supply good.
// RULE_14 - Soft-start current limit steps 70, 140, 280 then 750 mA.
// RULE_15 - PFM: high-side on while below threshold, until reached or peak trip.
// RULE_16 - Then low-side on until zero current; repeat high pulse if still low.
// RULE_17 - On reaching threshold, low-side until zero current, then both off idle.
// RULE_18 - Class G selects low rail, jumps to high rail when level is reached.
// RULE_19 - Class G drops to low rail only after a continuous hold time.
// RULE_20 - Hold counter clears on the level comparator; length is a parameter.
// RULE_21 - Step advances on a cycle count or limit hit; restarts on new trigger.
// RULE_22 - Writes are slave address 1100000, register byte, data byte, each acked.
// RULE_23 - All other register bits reset to 0.
`timescale 1ns/10ps
module hpac_top #(
  parameter int PD_CYCLES = hpac_pkg::PD_CYCLES,
  parameter int SS_STEP_CYCLES = hpac_pkg::SS_STEP_CYCLES,
  parameter int CLASSG_HOLD_CYCLES = hpac_pkg::CLASSG_HOLD_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic supply_good,
  input wire logic thermal_alarm,
  input wire logic pfm_below_high,
  input wire logic pfm_peak_trip,
  input wire logic zero_current,
  input wire logic classg_level,
  input wire logic ilim_reached,
  output logic left_amp_on,
  output logic right_amp_on,
  output logic left_mute,
  output logic right_mute,
  output logic [4:0] volume_level,
  output logic left_output_float,
  output logic right_output_float,
  output logic low_distortion_mode,
  output logic shutdown_busy,
  output logic device_asleep,
  output logic soft_start_active,
  output logic [1:0] current_limit_sel,
  output logic high_side_on,
  output logic low_side_on,
  output logic rail_high
);
  localparam logic [hpac_pkg::PD_CNT_W-1:0] PD_LAST =
    hpac_pkg::PD_CNT_W'(PD_CYCLES - 1);
  localparam logic [hpac_pkg::SS_CNT_W-1:0] SS_LAST = hpac_pkg::SS_CNT_W'(SS_STEP_CYCLES - 1);
  localparam logic [hpac_pkg::CG_CNT_W-1:0] CG_LAST =
    hpac_pkg::CG_CNT_W'(CLASSG_HOLD_CYCLES - 1);

  // Every outside input except rst passes two flops before use
  logic [hpac_pkg::IN_W-1:0] raw_in;
  logic [hpac_pkg::IN_W-1:0] sync1;
  logic [hpac_pkg::IN_W-1:0] sync2;
  logic scl_d;
  logic sda_d;
  assign raw_in = {ilim_reached, classg_level, zero_current, pfm_peak_trip, pfm_below_high,
                   thermal_alarm, supply_good, sda_in, scl_in};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // Bus lines idle high, so a low reset value would fake an edge
      sync1 <= '0;
      sync1[hpac_pkg::IN_SCL] <= 1'b1;
      sync1[hpac_pkg::IN_SDA] <= 1'b1;
      sync2 <= '0;
      sync2[hpac_pkg::IN_SCL] <= 1'b1;
      sync2[hpac_pkg::IN_SDA] <= 1'b1;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      scl_d <= sync2[hpac_pkg::IN_SCL];
      sda_d <= sync2[hpac_pkg::IN_SDA];
    end
  end

  logic scl_s, sda_s, scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_s = sync2[hpac_pkg::IN_SCL];
  assign sda_s = sync2[hpac_pkg::IN_SDA];
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

  // Register storage
  logic [7:0] mode_control;
  logic [7:0] volume_mute_control;
  logic [7:0] output_control;
  logic global_power_down;
  assign global_power_down = mode_control[hpac_pkg::MC_POWER_DOWN];

  // Serial slave
  hpac_pkg::hpac_i2c_type i2c_state;
  logic [7:0] shreg;
  logic [7:0] tx_byte;
  logic [7:0] reg_ptr;
  logic [2:0] bit_cnt;
  logic byte_done;
  logic read_dir;
  logic master_ack;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;

  function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] mc,
                                          input logic [7:0] vm, input logic [7:0] oc,
                                          input logic therm);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      hpac_pkg::ADDR_MODE: begin
        r = mc;
        r[hpac_pkg::MC_THERMAL] = therm;
      end
      hpac_pkg::ADDR_VOLUME: r = vm;
      hpac_pkg::ADDR_OUTPUT: r = oc;
      hpac_pkg::ADDR_INFO: r = hpac_pkg::INFO_VALUE;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  logic [7:0] rd_now;
  logic [7:0] rd_next;
  assign rd_now = read_mux(reg_ptr, mode_control, volume_mute_control, output_control,
                           sync2[hpac_pkg::IN_THERMAL]);
  assign rd_next = read_mux(reg_ptr + 8'h01, mode_control, volume_mute_control,
                            output_control, sync2[hpac_pkg::IN_THERMAL]);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      i2c_state <= hpac_pkg::I2C_IDLE;
      shreg <= 8'h00;
      tx_byte <= 8'h00;
      reg_ptr <= 8'h00;
      bit_cnt <= 3'h0;
      byte_done <= 1'b0;
      read_dir <= 1'b0;
      master_ack <= 1'b0;
      wr_stb <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      sda_out <= 1'b0;
      if (bus_start) begin
        i2c_state <= hpac_pkg::I2C_ADDR;
        bit_cnt <= 3'h0;
        byte_done <= 1'b0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        i2c_state <= hpac_pkg::I2C_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (i2c_state)
          hpac_pkg::I2C_ADDR, hpac_pkg::I2C_REG, hpac_pkg::I2C_WDATA: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s};
              bit_cnt <= bit_cnt + 3'h1;
              byte_done <= (bit_cnt == 3'h7);
            end else if (scl_fall && byte_done) begin
              byte_done <= 1'b0;
              sda_oe <= 1'b1; // RULE_22
              if (i2c_state == hpac_pkg::I2C_ADDR) begin
                read_dir <= shreg[0];
                if (shreg[7:1] == hpac_pkg::SLAVE_ADDR) begin // RULE_22
                  i2c_state <= hpac_pkg::I2C_ACK_ADDR;
                end else begin
                  i2c_state <= hpac_pkg::I2C_IDLE;
                  sda_oe <= 1'b0;
                end
              end else if (i2c_state == hpac_pkg::I2C_REG) begin
                reg_ptr <= shreg;
                i2c_state <= hpac_pkg::I2C_ACK_REG;
              end else begin
                wr_stb <= 1'b1;
                wr_addr <= reg_ptr;
                wr_data <= shreg;
                i2c_state <= hpac_pkg::I2C_ACK_DATA;
              end
            end
          end
          hpac_pkg::I2C_ACK_ADDR: begin
            if (scl_fall) begin
              bit_cnt <= 3'h0;
              if (read_dir) begin
                tx_byte <= rd_now;
                sda_oe <= ~rd_now[7];
                i2c_state <= hpac_pkg::I2C_RDATA;
              end else begin
                sda_oe <= 1'b0;
                i2c_state <= hpac_pkg::I2C_REG;
              end
            end
          end
          hpac_pkg::I2C_ACK_REG, hpac_pkg::I2C_ACK_DATA: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              bit_cnt <= 3'h0;
              // Further data bytes land on the following registers
              if (i2c_state == hpac_pkg::I2C_ACK_DATA) begin
                reg_ptr <= reg_ptr + 8'h01;
              end
              i2c_state <= hpac_pkg::I2C_WDATA;
            end
          end
          hpac_pkg::I2C_RDATA: begin
            if (scl_fall) begin
              bit_cnt <= bit_cnt + 3'h1;
              tx_byte <= {tx_byte[6:0], 1'b0};
              if (bit_cnt == 3'h7) begin
                sda_oe <= 1'b0;
                i2c_state <= hpac_pkg::I2C_RACK;
              end else begin
                sda_oe <= ~tx_byte[6];
              end
            end
          end
          hpac_pkg::I2C_RACK: begin
            if (scl_rise) begin
              master_ack <= ~sda_s;
            end else if (scl_fall) begin
              bit_cnt <= 3'h0;
              if (master_ack) begin
                reg_ptr <= reg_ptr + 8'h01;
                tx_byte <= rd_next;
                sda_oe <= ~rd_next[7];
                i2c_state <= hpac_pkg::I2C_RDATA;
              end else begin
                i2c_state <= hpac_pkg::I2C_IDLE;
              end
            end
          end
          default: i2c_state <= hpac_pkg::I2C_IDLE;
        endcase
      end
    end
  end

  // Register file; unused bits are masked so they read zero, except mode bit 1, which reads the thermal alarm
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_control <= hpac_pkg::MC_RESET; // RULE_05 RULE_23
      volume_mute_control <= hpac_pkg::VM_RESET; // RULE_12 RULE_23
      output_control <= hpac_pkg::OC_RESET; // RULE_23
    end else if (wr_stb) begin
      case (wr_addr)
        hpac_pkg::ADDR_MODE: mode_control <= wr_data & hpac_pkg::MC_WMASK; // RULE_04 RULE_06
        hpac_pkg::ADDR_VOLUME: volume_mute_control <= wr_data & hpac_pkg::VM_WMASK; // RULE_10
        hpac_pkg::ADDR_OUTPUT: output_control <= wr_data & hpac_pkg::OC_WMASK; // RULE_03
        default: ;
      endcase
    end
  end

  // Amplifier controls, each channel from its own bit; amp enables are also gated by global power down
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      left_amp_on <= 1'b0;
      right_amp_on <= 1'b0;
      left_mute <= 1'b1;
      right_mute <= 1'b1;
      volume_level <= 5'h00;
      left_output_float <= 1'b0;
      right_output_float <= 1'b0;
      low_distortion_mode <= 1'b0;
    end else begin
      left_amp_on <= mode_control[hpac_pkg::MC_LEFT_EN] & ~global_power_down; // RULE_06 RULE_07
      right_amp_on <= mode_control[hpac_pkg::MC_RIGHT_EN] & ~global_power_down; // RULE_07
      left_mute <= volume_mute_control[hpac_pkg::VM_MUTE_L]; // RULE_10 RULE_11
      right_mute <= volume_mute_control[hpac_pkg::VM_MUTE_R]; // RULE_11
      volume_level <= volume_mute_control[hpac_pkg::VM_VOL_HI:hpac_pkg::VM_VOL_LO];
      left_output_float <= output_control[hpac_pkg::OC_FLOAT_L]; // RULE_02
      right_output_float <= output_control[hpac_pkg::OC_FLOAT_R]; // RULE_01
      low_distortion_mode <= output_control[hpac_pkg::OC_LOW_DIST]; // RULE_03
    end
  end

  // Shutdown sequence; commands during it are not refused, the host must hold off
  logic gpd_d;
  logic [hpac_pkg::PD_CNT_W-1:0] pd_cnt;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gpd_d <= 1'b1;
      pd_cnt <= '0;
      shutdown_busy <= 1'b0;
      device_asleep <= 1'b1;
    end else begin
      gpd_d <= global_power_down;
      if (!global_power_down) begin
        shutdown_busy <= 1'b0;
        device_asleep <= 1'b0;
        pd_cnt <= '0;
      end else if (!gpd_d) begin
        shutdown_busy <= 1'b1; // RULE_08
        pd_cnt <= '0;
      end else if (shutdown_busy) begin
        if (pd_cnt == PD_LAST) begin
          shutdown_busy <= 1'b0; // RULE_08
          device_asleep <= 1'b1;
        end else begin
          pd_cnt <= pd_cnt + 1'b1;
        end
      end
    end
  end

  // Soft-start
  logic ss_trigger;
  logic [hpac_pkg::SS_CNT_W-1:0] ss_cnt;
  assign ss_trigger = gpd_d & ~global_power_down & sync2[hpac_pkg::IN_SUPPLY_OK]; // RULE_13
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      soft_start_active <= 1'b0;
      current_limit_sel <= hpac_pkg::ILIM_70MA;
      ss_cnt <= '0;
    end else if (global_power_down) begin
      soft_start_active <= 1'b0;
      current_limit_sel <= hpac_pkg::ILIM_70MA;
      ss_cnt <= '0;
    end else if (ss_trigger) begin
      soft_start_active <= 1'b1; // RULE_21
      current_limit_sel <= hpac_pkg::ILIM_70MA;
      ss_cnt <= '0;
    end else if (soft_start_active) begin
      if (ss_cnt == SS_LAST || sync2[hpac_pkg::IN_ILIM_HIT]) begin // RULE_21
        ss_cnt <= '0;
        current_limit_sel <= current_limit_sel + 2'h1; // RULE_14
        if (current_limit_sel == hpac_pkg::ILIM_750MA - 2'h1) begin
          soft_start_active <= 1'b0;
        end
      end else begin
        ss_cnt <= ss_cnt + 1'b1;
      end
    end
  end

  // PFM switch sequencing
  hpac_pkg::hpac_pfm_type pfm_state, next_pfm;
  logic below_s, peak_s, zero_s;
  assign below_s = sync2[hpac_pkg::IN_BELOW_HIGH];
  assign peak_s = sync2[hpac_pkg::IN_PEAK_TRIP];
  assign zero_s = sync2[hpac_pkg::IN_ZERO_CUR];
  always_comb begin
    next_pfm = pfm_state;
    case (pfm_state)
      hpac_pkg::PFM_IDLE: if (below_s) next_pfm = hpac_pkg::PFM_HIGH; // RULE_15
      hpac_pkg::PFM_HIGH: begin
        if (!below_s) next_pfm = hpac_pkg::PFM_TAIL; // RULE_17
        else if (peak_s) next_pfm = hpac_pkg::PFM_LOW; // RULE_15
      end
      hpac_pkg::PFM_LOW: begin
        if (zero_s) next_pfm = below_s ? hpac_pkg::PFM_HIGH : hpac_pkg::PFM_IDLE; // RULE_16
      end
      hpac_pkg::PFM_TAIL: if (zero_s) next_pfm = hpac_pkg::PFM_IDLE; // RULE_17
      default: next_pfm = hpac_pkg::PFM_IDLE;
    endcase
    if (global_power_down) next_pfm = hpac_pkg::PFM_IDLE;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pfm_state <= hpac_pkg::PFM_IDLE;
      high_side_on <= 1'b0;
      low_side_on <= 1'b0;
    end else begin
      pfm_state <= next_pfm;
      high_side_on <= (next_pfm == hpac_pkg::PFM_HIGH); // RULE_15
      low_side_on <= (next_pfm == hpac_pkg::PFM_LOW) || (next_pfm == hpac_pkg::PFM_TAIL); // RULE_16
    end
  end

  // Class G rail choice; the hold counter rides out short dips below the level
  logic level_s;
  logic [hpac_pkg::CG_CNT_W-1:0] cg_cnt;
  assign level_s = sync2[hpac_pkg::IN_CLASSG_LVL];
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rail_high <= 1'b0; // RULE_18
      cg_cnt <= '0;
    end else if (level_s) begin
      rail_high <= 1'b1; // RULE_18
      cg_cnt <= '0; // RULE_20
    end else if (rail_high) begin
      if (cg_cnt == CG_LAST) begin
        rail_high <= 1'b0; // RULE_19
        cg_cnt <= '0;
      end else begin
        cg_cnt <= cg_cnt + 1'b1; // RULE_20
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_wr(logic [7:0] a);
    wr_stb && wr_addr == a;
  endsequence

  chk_right_float: assert property (s_wr(hpac_pkg::ADDR_OUTPUT) |-> ##2 // RULE_01
    right_output_float == $past(wr_data[0], 2)) else $error("right float mismatch");
  chk_left_float: assert property (s_wr(hpac_pkg::ADDR_OUTPUT) |-> ##2 // RULE_02
    left_output_float == $past(wr_data[1], 2)) else $error("left float mismatch");
  chk_low_dist_mode: assert property (s_wr(hpac_pkg::ADDR_OUTPUT) |-> ##2 // RULE_03
    low_distortion_mode == $past(wr_data[3], 2)) else $error("low distortion mismatch");
  chk_left_enable: assert property (s_wr(hpac_pkg::ADDR_MODE) |-> ##2 // RULE_06
    left_amp_on == ($past(wr_data[7], 2) && !$past(wr_data[0], 2)))
    else $error("left enable mismatch");
  chk_mute_indep: assert property (s_wr(hpac_pkg::ADDR_VOLUME) |-> ##2 // RULE_10
    left_mute == $past(wr_data[7], 2) && right_mute == $past(wr_data[6], 2))
    else $error("mute bits mismatch");
  chk_reset_values: assert property (disable iff (1'b0) rst |=> // RULE_05
    mode_control == hpac_pkg::MC_RESET && volume_mute_control == hpac_pkg::VM_RESET &&
    output_control == hpac_pkg::OC_RESET) else $error("reset values wrong");
  chk_pd_start: assert property ($rose(global_power_down) |=> shutdown_busy) // RULE_08
    else $error("shutdown sequence not started");
  chk_pd_bound: assert property (shutdown_busy |-> pd_cnt <= PD_LAST) // RULE_08
    else $error("shutdown overran");
  chk_ss_start: assert property (ss_trigger |=> soft_start_active && // RULE_13
    current_limit_sel == hpac_pkg::ILIM_70MA) else $error("soft-start start wrong");
  chk_ss_steps: assert property ($changed(current_limit_sel) && soft_start_active && // RULE_14
    !$past(ss_trigger) |-> current_limit_sel == $past(current_limit_sel) + 2'h1)
    else $error("current limit skipped a step");
  chk_pfm_tail: assert property (pfm_state == hpac_pkg::PFM_HIGH && !below_s && // RULE_17
    !global_power_down |=> !high_side_on && low_side_on) else $error("tail not entered");
  chk_pfm_exclusive: assert property (!(high_side_on && low_side_on)) // RULE_15
    else $error("both switches on");
  chk_rail_up: assert property (level_s |=> rail_high) else $error("rail not raised"); // RULE_18
  chk_rail_hold: assert property (rail_high && !level_s && cg_cnt != CG_LAST |=> // RULE_19
    rail_high) else $error("rail dropped early");
  chk_addr_ack: assert property (i2c_state == hpac_pkg::I2C_ACK_ADDR |-> sda_oe) // RULE_22
    else $error("address not acknowledged");
endmodule

// ---- hdl/hpac_pkg.sv ----
// Constants shared by the headphone amplifier control block
package hpac_pkg;
  // Bus identity and register map
  localparam logic [6:0] SLAVE_ADDR = 7'h60;
  localparam logic [7:0] ADDR_MODE = 8'h01;
  localparam logic [7:0] ADDR_VOLUME = 8'h02;
  localparam logic [7:0] ADDR_OUTPUT = 8'h03;
  localparam logic [7:0] ADDR_INFO = 8'h04;
  // Arbitrary neutral value, not the part's own
  localparam logic [7:0] INFO_VALUE = 8'h5a;
  // Field positions
  localparam int MC_LEFT_EN = 7;
  localparam int MC_RIGHT_EN = 6;
  localparam int MC_THERMAL = 1;
  localparam int MC_POWER_DOWN = 0;
  localparam int VM_MUTE_L = 7;
  localparam int VM_MUTE_R = 6;
  localparam int VM_VOL_HI = 5;
  localparam int VM_VOL_LO = 1;
  localparam int OC_LOW_DIST = 3;
  localparam int OC_FLOAT_L = 1;
  localparam int OC_FLOAT_R = 0;
  // Reset values and writable masks
  localparam logic [7:0] MC_RESET = 8'h01;
  localparam logic [7:0] VM_RESET = 8'hc0;
  localparam logic [7:0] OC_RESET = 8'h00;
  localparam logic [7:0] MC_WMASK = 8'hc1;
  localparam logic [7:0] VM_WMASK = 8'hfe;
  localparam logic [7:0] OC_WMASK = 8'h0b;
  // Timing
  localparam int CLK_FREQ_HZ = 40_000_000;
  localparam int PD_TIME_US = 3000;
  localparam int PD_CYCLES = PD_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int PD_CNT_W = 17;
  localparam int SS_STEP_CYCLES = 400;
  localparam int SS_CNT_W = 12;
  localparam int CLASSG_HOLD_CYCLES = 2000;
  localparam int CG_CNT_W = 12;
  // Soft-start current limit steps: 70, 140, 280, 750 mA
  localparam logic [1:0] ILIM_70MA = 2'h0;
  localparam logic [1:0] ILIM_750MA = 2'h3;
  // Synchronised input vector positions
  localparam int IN_SCL = 0;
  localparam int IN_SDA = 1;
  localparam int IN_SUPPLY_OK = 2;
  localparam int IN_THERMAL = 3;
  localparam int IN_BELOW_HIGH = 4;
  localparam int IN_PEAK_TRIP = 5;
  localparam int IN_ZERO_CUR = 6;
  localparam int IN_CLASSG_LVL = 7;
  localparam int IN_ILIM_HIT = 8;
  localparam int IN_W = 9;

  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_ACK_ADDR, I2C_REG, I2C_ACK_REG,
    I2C_WDATA, I2C_ACK_DATA, I2C_RDATA, I2C_RACK
  } hpac_i2c_type;

  typedef enum logic [2:0] {
    PFM_IDLE, PFM_HIGH, PFM_LOW, PFM_TAIL
  } hpac_pfm_type;
endpackage

// ---- verif/hpac_host.sv ----
// Serial bus host master model for the amplifier control block
`timescale 1ns/10ps
module hpac_host (
  input wire logic clk_sys,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Eight cycles a phase keeps clear of the two-flop input sync
  task automatic hp();
    repeat (8) @(negedge clk_sys);
  endtask
  task automatic bit_io(input logic pull, output logic seen);
    sda_pull = pull;
    hp();
    scl = 1'b1;
    hp();
    seen = sda_line;
    scl = 1'b0;
    hp();
  endtask
  task automatic start();
    sda_pull = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_pull = 1'b1;
    hp();
    scl = 1'b0;
    hp();
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_pull = 1'b0;
    hp();
  endtask
  // Sends tx MSB first, returns what the line carried and the ninth bit inverted as ack
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(!tx[i], s);
      rx[i] = s;
    end
    bit_io(mack, s);
    ack = !s;
    sda_pull = 1'b0;
  endtask
  task automatic wr(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] d,
                    output logic ok);
    logic [7:0] r;
    logic k0, k1, k2;
    start();
    xfer(dev, 1'b0, r, k0);
    xfer(a, 1'b0, r, k1);
    xfer(d, 1'b0, r, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] r;
    logic k;
    start();
    xfer({hpac_pkg::SLAVE_ADDR, 1'b0}, 1'b0, r, k);
    xfer(a, 1'b0, r, k);
    start();
    xfer({hpac_pkg::SLAVE_ADDR, 1'b1}, 1'b0, r, k);
    xfer(8'hff, 1'b0, d, k);
    stop();
  endtask
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the headphone amplifier control block
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
  // Longer than the tail of the write that starts it, so busy is still seen
  localparam int SHD = 200;
  localparam logic [7:0] DEV = {hpac_pkg::SLAVE_ADDR, 1'b0};
  localparam logic [7:0] MV [4] = '{8'h80, 8'h40, 8'hc0, 8'h00};
  localparam logic [7:0] VV [4] = '{8'h80, 8'h40, 8'h3e, 8'hc0};
  logic clk_sys, rst, sup, thr, blw, pk, zc, cgl, ilh, scl, pull, sda_out, sda_oe, sda;
  logic l_on, r_on, l_m, r_m, l_f, r_f, ld, busy, asl, ss, hs, ls, rh, ok, ss_q;
  logic [4:0] vol;
  logic [1:0] sel, sel_q;
  logic [7:0] rd, wv;
  int num_errors = 0;
  int checks = 0;
  int ss_rises = 0;
  // Open-drain data line with pull-up
  assign sda = !(pull | (sda_oe & !sda_out));
  hpac_host u_host (.clk_sys(clk_sys), .sda_line(sda), .scl(scl), .sda_pull(pull));
  hpac_top #(.PD_CYCLES(SHD), .SS_STEP_CYCLES(8), .CLASSG_HOLD_CYCLES(10)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .supply_good(sup), .thermal_alarm(thr), .pfm_below_high(blw),
    .pfm_peak_trip(pk), .zero_current(zc), .classg_level(cgl), .ilim_reached(ilh),
    .left_amp_on(l_on), .right_amp_on(r_on), .left_mute(l_m), .right_mute(r_m),
    .volume_level(vol), .left_output_float(l_f), .right_output_float(r_f),
    .low_distortion_mode(ld), .shutdown_busy(busy), .device_asleep(asl),
    .soft_start_active(ss), .current_limit_sel(sel), .high_side_on(hs),
    .low_side_on(ls), .rail_high(rh));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = !clk_sys;
  end
  always @(negedge clk_sys) begin
    if (ss && !ss_q) begin
      ss_rises++;
      `CHK("ss_first", 2'h0, sel)
    end
    if (ss && ss_q && sel !== sel_q) `CHK("ss_step", sel_q + 2'h1, sel)
    if (!ss && ss_q) `CHK("ss_last", 2'h3, sel)
    ss_q = ss;
    sel_q = sel;
  end
  task automatic give_verdict();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic pfm(input logic [2:0] in, input logic [1:0] e);
    {blw, pk, zc} = in;
    wt(6);
    `CHK("pfm", e, {hs, ls})
  endtask
  initial begin
    wt(40000);
    num_errors++;
    give_verdict();
  end
  initial begin
    {sup, thr, blw, pk, zc, cgl, ilh} = '0;
    rst = 1'b1;
    wt(16);
    rst = 1'b0;
    wt(8);
    `CHK("mutes", 2'b11, {l_m, r_m})
    `CHK("asleep", 1'b1, asl)
    `CHK("amps", 2'b00, {l_on, r_on})
    `CHK("out_pins", 3'b000, {ld, l_f, r_f})
    `CHK("rail", 1'b0, rh)
    `CHK("sda_idle", 2'b00, {sda_oe, sda_out})
    u_host.rd(hpac_pkg::ADDR_MODE, rd);
    `CHK("rd_mode", 8'h01, rd)
    u_host.rd(hpac_pkg::ADDR_VOLUME, rd);
    `CHK("rd_vol", 8'hc0, rd)
    u_host.rd(hpac_pkg::ADDR_OUTPUT, rd);
    `CHK("rd_out", 8'h00, rd)
    u_host.wr(8'ha0, hpac_pkg::ADDR_OUTPUT, 8'h0b, ok);
    `CHK("foreign_ack", 1'b0, ok)
    for (int i = 0; i < 4; i++) begin
      wv = 8'h01 << i;
      u_host.wr(DEV, hpac_pkg::ADDR_OUTPUT, wv, ok);
      `CHK("ack", 1'b1, ok)
      `CHK("out_pins", {wv[3], wv[1], wv[0]}, {ld, l_f, r_f})
    end
    sup = 1'b1;
    for (int i = 0; i < 4; i++) begin
      u_host.wr(DEV, hpac_pkg::ADDR_MODE, MV[i], ok);
      `CHK("amps", MV[i][7:6], {l_on, r_on})
      u_host.wr(DEV, hpac_pkg::ADDR_VOLUME, VV[i], ok);
      `CHK("mute_vol", {VV[i][7:6], VV[i][5:1]}, {l_m, r_m, vol})
    end
    `CHK("ss_count", 1, ss_rises)
    u_host.wr(DEV, hpac_pkg::ADDR_MODE, 8'hc1, ok);
    `CHK("sd_busy", 3'b100, {busy, l_on, r_on})
    wt(SHD);
    `CHK("sd_done", 2'b01, {busy, asl})
    sup = 1'b0;
    u_host.wr(DEV, hpac_pkg::ADDR_MODE, 8'h00, ok);
    wt(40);
    `CHK("ss_count", 1, ss_rises)
    sup = 1'b1;
    u_host.wr(DEV, hpac_pkg::ADDR_MODE, 8'h01, ok);
    wt(SHD);
    ilh = 1'b1;
    u_host.wr(DEV, hpac_pkg::ADDR_MODE, 8'h00, ok);
    wt(20);
    `CHK("ss_count", 2, ss_rises)
    ilh = 1'b0;
    pfm(3'b100, 2'b10);
    pfm(3'b110, 2'b01);
    pfm(3'b101, 2'b10);
    pfm(3'b000, 2'b01);
    pfm(3'b001, 2'b00);
    pfm(3'b000, 2'b00);
    cgl = 1'b1;
    wt(6);
    `CHK("rail", 1'b1, rh)
    cgl = 1'b0;
    wt(8);
    `CHK("rail", 1'b1, rh)
    cgl = 1'b1;
    wt(1);
    cgl = 1'b0;
    wt(10);
    `CHK("rail", 1'b1, rh)
    wt(10);
    `CHK("rail", 1'b0, rh)
    give_verdict();
  end
endmodule
